// ---- gis_sequencer.sv ----
// Gapped/seamless integration sequencer of a dual-integrator charge converter
// Notes on behaviour
// RULE_01: Gapped mode integrates a pair A/B, then idles while both are measured.
// RULE_02: Integration-only states three and six wait for both measurements.
// RULE_03: After both measurements a preparation state readies the next side.
// RULE_04: First data ready follows first integration end; second follows later.
// RULE_05: Typical gapped sequence walks states three, four, one, two repeatedly.
// RULE_06: States one and eight hold until measure busy drops, select ignored.
// RULE_07: State two goes to three once select is high; seven mirrors it.
// RULE_08: Controller keeps preparation state long enough; device does not check.
// RULE_09: Controller keeps gapped integrations between 50 us and 1 s.
// RULE_10: Conversion phase lasts 202.2 us, reset phase 13.2 us, at reference clock.
// RULE_11: Gapped integrator plus converter reset lasts 37.8 us at reference clock.
// RULE_12: Gapped conversion and reset for both sides lasts 910.8 us.
// RULE_13: Toggle while measuring falls from seamless into gapped operation.
// RULE_14: On the fall, measure B then A in eight, prepare in seven, resume in six.
// RULE_15: Toggles spaced at least the seamless cycle keep seamless integration.
// RULE_16: First integration in state three may be short; nothing to wait for.
// RULE_17: Seamless measure/reset/autozero cycle takes 4794 master clocks.
// RULE_18: Gapped measure/reset/autozero for both sides takes 9108 master clocks.
// RULE_19: First data ready 4212 clocks after toggle, second 4548 after first.
// RULE_20: Data ready stays low until transmit request goes low.
// RULE_21: Select is sampled every clock as a level, not an edge.
`timescale 1ns/1ps
`default_nettype none
`include "gis_regs.svh"

module gis_sequencer #(
  parameter int unsigned SEAMLESS_CYCLES = `GIS_SEAMLESS_CYCLES,
  parameter int unsigned GAPPED_CYCLES = `GIS_GAPPED_CYCLES,
  parameter int unsigned FIRST_READY_CYCLES = `GIS_FIRST_READY_CYCLES,
  parameter int unsigned SECOND_READY_CYCLES = `GIS_SECOND_READY_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_integrate_select,
  input wire logic i_transmit_request_n,
  output logic o_data_ready_n,
  output logic o_data_side_b,
  output gis_pkg::gis_state_e o_state,
  output logic o_measure_busy,
  output logic o_converting,
  output logic o_integrating_a,
  output logic o_integrating_b
);

  localparam logic [13:0] SEAM_LEN = 14'(SEAMLESS_CYCLES);
  localparam logic [13:0] GAP_LEN = 14'(GAPPED_CYCLES);
  localparam logic [13:0] FIRST_AT = 14'(FIRST_READY_CYCLES);
  localparam logic [13:0] SECOND_AT = 14'(FIRST_READY_CYCLES + SECOND_READY_CYCLES);
  localparam logic [13:0] INTEGRATE_SELECT_FROM = 14'(`GIS_INTEGRATE_SELECT_RESET_CYCLES);
  localparam logic [13:0] INTEGRATE_SELECT_TO = 14'(`GIS_INTEGRATE_SELECT_RESET_CYCLES + `GIS_INTEGRATE_SELECT_CYCLES);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sel_meta_q, sel_q, txr_meta_q, txr_n_q;
  logic sel_meta_d, sel_d, txr_meta_d, txr_n_d;

  // Both pins are asynchronous to the master clock
  always_comb begin
    sel_meta_d = i_integrate_select;
    sel_d = sel_meta_q;
    txr_meta_d = i_transmit_request_n;
    txr_n_d = txr_meta_q;
  end

  always_ff @(posedge i_clk) begin
    sel_meta_q <= sel_meta_d;
    sel_q <= sel_d;
    txr_meta_q <= txr_meta_d;
    txr_n_q <= txr_n_d;
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  gis_pkg::gis_state_e state_q, state_d;
  gis_pkg::gis_meas_s meas_q, meas_d;
  logic int_end; // An integration ends this cycle

  // Level of select decides each step except from states one and eight; busy gates the gapped states
  always_comb begin
    state_d = state_q;
    int_end = 1'b0;
    unique case (state_q)
      gis_pkg::ST_MEAS_A_B: begin
        if (!meas_q.busy) state_d = gis_pkg::ST_PREP_A; // RULE_06 RULE_03
      end
      gis_pkg::ST_PREP_A: begin
        if (sel_q) state_d = gis_pkg::ST_INT_A; // RULE_07 RULE_21
      end
      gis_pkg::ST_INT_A: begin
        if (!sel_q) begin
          state_d = gis_pkg::ST_INT_B_MEAS_A; // RULE_16 RULE_05
          int_end = 1'b1;
        end
      end
      gis_pkg::ST_INT_B_MEAS_A: begin
        if (sel_q) begin
          int_end = 1'b1;
          // Toggle while busy drops to the gapped states
          state_d = meas_q.busy ? gis_pkg::ST_MEAS_A_B : gis_pkg::ST_INT_A_MEAS_B; // RULE_13 RULE_15 RULE_01
        end
      end
      gis_pkg::ST_INT_A_MEAS_B: begin
        if (!sel_q) begin
          int_end = 1'b1;
          state_d = meas_q.busy ? gis_pkg::ST_MEAS_B_A : gis_pkg::ST_INT_B_MEAS_A; // RULE_13 RULE_14
        end
      end
      gis_pkg::ST_INT_B: begin
        if (sel_q) begin
          state_d = gis_pkg::ST_INT_A_MEAS_B;
          int_end = 1'b1;
        end
      end
      gis_pkg::ST_PREP_B: begin
        if (!sel_q) state_d = gis_pkg::ST_INT_B; // RULE_07 RULE_14
      end
      gis_pkg::ST_MEAS_B_A: begin
        if (!meas_q.busy) state_d = gis_pkg::ST_PREP_B; // RULE_06 RULE_02
      end
    endcase
    // Power-up state follows the select level
    if (i_rst) state_d = sel_q ? gis_pkg::ST_MEAS_A_B : gis_pkg::ST_MEAS_B_A;
  end

  always_ff @(posedge i_clk) begin
    state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Measurement engine
  // ----------------------------------------------------------------
  logic [13:0] meas_len;
  logic fire_first, fire_second;

  // One elapsed count serves both modes; a second end while busy
  // stretches the cycle to the gapped length instead of restarting it
  always_comb begin
    meas_d = meas_q;
    meas_len = meas_q.pair ? GAP_LEN : SEAM_LEN; // RULE_17 RULE_18
    fire_first = meas_q.busy && (meas_q.elapsed == FIRST_AT); // RULE_19 RULE_04
    fire_second = meas_q.busy && meas_q.pair && (meas_q.elapsed == SECOND_AT); // RULE_19
    if (meas_q.busy) begin
      meas_d.elapsed = meas_q.elapsed + 14'h0001;
      if (meas_q.elapsed + 14'h0001 >= meas_len) meas_d.busy = 1'b0;
    end
    if (int_end) begin
      if (meas_q.busy) begin
        meas_d.pair = 1'b1; // RULE_01 RULE_12
      end else begin
        meas_d.busy = 1'b1;
        meas_d.pair = 1'b0;
        meas_d.elapsed = 14'h0000;
      end
    end
    // Converter active after its reset phase, for one conversion
    meas_d.converting = meas_d.busy && (meas_d.elapsed >= INTEGRATE_SELECT_FROM)
      && (meas_d.elapsed < INTEGRATE_SELECT_TO); // RULE_10 RULE_11
    if (i_rst) meas_d = '0;
  end

  always_ff @(posedge i_clk) begin
    meas_q <= meas_d;
  end

  // ----------------------------------------------------------------
  // Data ready
  // ----------------------------------------------------------------
  logic dr_n_q, dr_n_d, side_q, side_d, first_side_q, first_side_d;
  logic [13:0] rdy_wait_q, rdy_wait_d; // Cycles since an idle measurement began

  // Side of the first pending result is the side that just stopped
  always_comb begin
    first_side_d = first_side_q;
    rdy_wait_d = rdy_wait_q;
    if (int_end && !meas_q.busy) first_side_d = (state_q == gis_pkg::ST_INT_B_MEAS_A)
      || (state_q == gis_pkg::ST_INT_B);
    if (rdy_wait_q != 14'h0000) begin
      rdy_wait_d = (rdy_wait_q == FIRST_AT + 14'h0002) ? 14'h0000 : rdy_wait_q + 14'h0001;
    end
    if (int_end && !meas_q.busy) rdy_wait_d = 14'h0001; // Own count, not the elapsed field
    if (i_rst) first_side_d = 1'b0;
    if (i_rst) rdy_wait_d = 14'h0000;
  end

  // New result wins over a transmit request in the same cycle
  always_comb begin
    dr_n_d = dr_n_q;
    side_d = side_q;
    if (!txr_n_q) dr_n_d = 1'b1; // RULE_20
    if (fire_first) begin
      dr_n_d = 1'b0; // RULE_04
      side_d = first_side_q;
    end
    if (fire_second) begin
      dr_n_d = 1'b0;
      side_d = !first_side_q;
    end
    if (i_rst) begin
      dr_n_d = 1'b1;
      side_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    dr_n_q <= dr_n_d;
    side_q <= side_d;
    first_side_q <= first_side_d;
    rdy_wait_q <= rdy_wait_d;
  end

  // Outputs straight from flip-flops or state decode
  assign o_data_ready_n = dr_n_q;
  assign o_data_side_b = side_q;
  assign o_state = state_q;
  assign o_measure_busy = meas_q.busy;
  assign o_converting = meas_q.converting;
  assign o_integrating_a = (state_q == gis_pkg::ST_INT_A) || (state_q == gis_pkg::ST_INT_A_MEAS_B);
  assign o_integrating_b = (state_q == gis_pkg::ST_INT_B) || (state_q == gis_pkg::ST_INT_B_MEAS_A);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold_gap;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == gis_pkg::ST_MEAS_A_B && meas_q.busy) |=> (state_q == gis_pkg::ST_MEAS_A_B);
  endproperty
  a_hold_gap: assert property (p_hold_gap) else $error("left state one while busy"); // RULE_06

  property p_no_int_busy;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == gis_pkg::ST_INT_A || state_q == gis_pkg::ST_INT_B) && $changed(state_q)
      |-> $past(state_q) inside {gis_pkg::ST_PREP_A, gis_pkg::ST_PREP_B};
  endproperty
  a_no_int_busy: assert property (p_no_int_busy) else $error("state three/six not via prep"); // RULE_02

  property p_prep_go;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == gis_pkg::ST_PREP_A && sel_q) |=> (state_q == gis_pkg::ST_INT_A);
  endproperty
  a_prep_go: assert property (p_prep_go) else $error("prep did not advance"); // RULE_07

  property p_prep_after;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == gis_pkg::ST_MEAS_B_A && !meas_q.busy) |=> (state_q == gis_pkg::ST_PREP_B);
  endproperty
  a_prep_after: assert property (p_prep_after) else $error("no prep after measure"); // RULE_03

  property p_fall_gap;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == gis_pkg::ST_INT_A_MEAS_B && !sel_q && meas_q.busy)
      |=> (state_q == gis_pkg::ST_MEAS_B_A);
  endproperty
  a_fall_gap: assert property (p_fall_gap) else $error("no fall to gapped"); // RULE_13

  property p_first_ready;
    @(posedge i_clk) disable iff (i_rst)
    (rdy_wait_q == FIRST_AT + 14'h0002) |-> !dr_n_q;
  endproperty
  a_first_ready: assert property (p_first_ready) else $error("first ready late"); // RULE_19

  property p_seam_len;
    @(posedge i_clk) disable iff (i_rst)
    (meas_q.busy && !meas_q.pair && meas_q.elapsed == SEAM_LEN - 14'h0001) |=> !meas_q.busy;
  endproperty
  a_seam_len: assert property (p_seam_len) else $error("seamless cycle length wrong"); // RULE_17

  property p_gap_len;
    @(posedge i_clk) disable iff (i_rst)
    (meas_q.busy && meas_q.pair && meas_q.elapsed < GAP_LEN - 14'h0001) |=> meas_q.busy;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gapped cycle ended early"); // RULE_18

  property p_ready_hold;
    @(posedge i_clk) disable iff (i_rst)
    (!dr_n_q && txr_n_q) |=> !dr_n_q;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready released early"); // RULE_20

  c_gapped: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == gis_pkg::ST_MEAS_A_B ##[1:1000] state_q == gis_pkg::ST_PREP_A);
  c_fall: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == gis_pkg::ST_MEAS_B_A ##1 state_q == gis_pkg::ST_PREP_B);
  c_second: cover property (@(posedge i_clk) disable iff (i_rst) fire_second);

endmodule // gis_sequencer
`default_nettype wire

// ---- gis_regs.svh ----
// Timing constants of the gapped integration sequencer
`ifndef GIS_REGS_SVH
`define GIS_REGS_SVH

// ----------------------------------------------------------------
// Master clock and reference rate
// ----------------------------------------------------------------
`define GIS_CLK_PERIOD_PS 10000
`define GIS_REF_PERIOD_PS 100000

// ----------------------------------------------------------------
// Cycle counts in master clock periods
// ----------------------------------------------------------------
`define GIS_SEAMLESS_CYCLES 4794
`define GIS_GAPPED_CYCLES 9108
`define GIS_FIRST_READY_CYCLES 4212
`define GIS_SECOND_READY_CYCLES 4548

// ----------------------------------------------------------------
// Internal phase times at the reference rate, in ps
// ----------------------------------------------------------------
`define GIS_INTEGRATE_SELECT_TIME_PS 202200000
`define GIS_INTEGRATE_SELECT_RESET_PS 13200000
`define GIS_GAP_RESET_PS 37800000
`define GIS_GAP_TOTAL_PS 910800000

// Phase lengths in reference periods, derived from the times above
`define GIS_INTEGRATE_SELECT_CYCLES (`GIS_INTEGRATE_SELECT_TIME_PS / `GIS_REF_PERIOD_PS)
`define GIS_INTEGRATE_SELECT_RESET_CYCLES (`GIS_INTEGRATE_SELECT_RESET_PS / `GIS_REF_PERIOD_PS)
`define GIS_GAP_RESET_CYCLES (`GIS_GAP_RESET_PS / `GIS_REF_PERIOD_PS)
`define GIS_GAP_TOTAL_CYCLES (`GIS_GAP_TOTAL_PS / `GIS_REF_PERIOD_PS)

`endif

// ---- gis_pkg.sv ----
// Types of the gapped integration sequencer
`default_nettype none
package gis_pkg;
  // Sequencer states, one to eight in order
  typedef enum logic [2:0] {
    ST_MEAS_A_B,
    ST_PREP_A,
    ST_INT_A,
    ST_INT_B_MEAS_A,
    ST_INT_A_MEAS_B,
    ST_INT_B,
    ST_PREP_B,
    ST_MEAS_B_A
  } gis_state_e;

  // Measurement engine status
  typedef struct packed {
    logic busy;
    logic pair;
    logic converting;
    logic [13:0] elapsed;
  } gis_meas_s;
endpackage
`default_nettype wire

// ---- gis_ctrl_model.sv ----
// Controller model driving the select level and answering data ready
`timescale 1ns/1ps
`default_nettype none
module gis_ctrl_model (
  input wire logic i_clk,
  input wire logic i_cmd_select,
  input wire logic i_slow,
  input wire logic i_data_ready_n,
  output logic o_integrate_select,
  output var logic o_transmit_request_n = 1'b1
);
  int wait_q = 0;
  // Select follows the bench directly; nothing here keeps spacing or length legal
  assign o_integrate_select = i_cmd_select;
  // Request a result some cycles after ready; slow mode tests the hold
  always @(negedge i_clk) begin
    if (i_data_ready_n !== 1'b0) begin
      wait_q <= 0;
      o_transmit_request_n <= 1'b1;
    end else if (wait_q < (i_slow ? 8 : 2)) begin
      wait_q <= wait_q + 1;
    end else begin
      o_transmit_request_n <= 1'b0;
    end
  end
endmodule // gis_ctrl_model
`default_nettype wire

// ---- tb_gapped_integration_sequencer.sv ----
// Self-checking bench of the gapped integration sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_gapped_integration_sequencer;
  // Short counts keep the run brief
  localparam int SC = 40;
  localparam int GC = 90;
  localparam int FR = 20;
  localparam int SR = 30;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sel = 1'b1;
  logic slow = 1'b0;
  logic i_integrate_select;
  logic i_transmit_request_n;
  logic o_data_ready_n;
  logic o_data_side_b;
  logic o_measure_busy;
  logic integrate_select;
  logic int_a;
  logic int_b;
  gis_pkg::gis_state_e o_state;
  logic rdy_q = 1'b1;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rt[$];
  logic rs[$];
  gis_pkg::gis_state_e seq[$];

  always #5 i_clk = ~i_clk;

  gis_sequencer #(
    .SEAMLESS_CYCLES(SC),
    .GAPPED_CYCLES(GC),
    .FIRST_READY_CYCLES(FR),
    .SECOND_READY_CYCLES(SR)
  ) uut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_integrate_select(i_integrate_select),
    .i_transmit_request_n(i_transmit_request_n),
    .o_data_ready_n(o_data_ready_n),
    .o_data_side_b(o_data_side_b),
    .o_state(o_state),
    .o_measure_busy(o_measure_busy),
    .o_converting(integrate_select),
    .o_integrating_a(int_a),
    .o_integrating_b(int_b)
  );

  gis_ctrl_model u_ctrl (
    .i_clk(i_clk),
    .i_cmd_select(sel),
    .i_slow(slow),
    .i_data_ready_n(o_data_ready_n),
    .o_integrate_select(i_integrate_select),
    .o_transmit_request_n(i_transmit_request_n)
  );

  // Log ready falls and state changes; sampled before the edge updates
  always @(posedge i_clk) begin
    cyc++;
    if (o_data_ready_n === 1'b0 && rdy_q === 1'b1) begin
      rt.push_back(cyc);
      rs.push_back(o_data_side_b);
    end
    rdy_q = o_data_ready_n;
    if (!i_rst && (seq.size() == 0 || seq[$] !== o_state)) begin
      seq.push_back(o_state);
    end
  end

  // ----------------------------------------------------------------
  // Shared checks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      failures++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Bounded wait; the bound is the allowed latency
  task automatic wait_st(input gis_pkg::gis_state_e st, input int lim);
    int n;
    n = 0;
    while (o_state !== st && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk("state", st, o_state);
  endtask

  // One more edge lets the log catch the current state
  task automatic tail3(input logic [8:0] e);
    @(negedge i_clk);
    chk("states", e, {seq[$-2], seq[$-1], seq[$]});
  endtask

  // Four edges cover the select synchroniser
  task automatic rst(input logic s);
    @(negedge i_clk);
    i_rst = 1'b1;
    sel = s;
    repeat (4) @(negedge i_clk);
    chk("reset state", s ? gis_pkg::ST_MEAS_A_B : gis_pkg::ST_MEAS_B_A, o_state);
    chk("reset ready", 1'b1, o_data_ready_n);
    i_rst = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rst(1'b0);
    wait_st(gis_pkg::ST_INT_B, 6);
    tail3({gis_pkg::ST_MEAS_B_A, gis_pkg::ST_PREP_B, gis_pkg::ST_INT_B});
    rst(1'b1);
    wait_st(gis_pkg::ST_INT_A, 6);
    tail3({gis_pkg::ST_MEAS_A_B, gis_pkg::ST_PREP_A, gis_pkg::ST_INT_A});
    $display("test reset done");
  endtask

  task automatic t_gapped();
    int t4;
    repeat (10) @(negedge i_clk);
    chk("int a", 1'b1, int_a);
    sel = 1'b0;
    wait_st(gis_pkg::ST_INT_B_MEAS_A, 4);
    t4 = cyc;
    rt.delete();
    rs.delete();
    repeat (5) @(negedge i_clk);
    sel = 1'b1;
    wait_st(gis_pkg::ST_MEAS_A_B, 4);
    // Select wiggles are ignored while measuring; stop early to hold prep
    while (o_measure_busy === 1'b1 && cyc - t4 < 200) begin
      chk("meas hold", gis_pkg::ST_MEAS_A_B, o_state);
      // Short counts end before the converter reset phase is over
      chk("converting", 1'b0, integrate_select);
      sel = (cyc - t4 < GC - 10) ? ~sel : 1'b0;
      @(negedge i_clk);
    end
    chk_in("busy", GC - 1, GC + 2, cyc - t4);
    wait_st(gis_pkg::ST_PREP_A, 4);
    tail3({gis_pkg::ST_INT_B_MEAS_A, gis_pkg::ST_MEAS_A_B, gis_pkg::ST_PREP_A});
    chk("ready count", 2, rt.size());
    chk_in("ready 1", FR - 2, FR + 4, rt[0] - t4);
    chk("ready 2", SR, rt[1] - rt[0]);
    chk("sides", 2'b01, {rs[0], rs[1]});
    repeat (10) @(negedge i_clk);
    chk("prep hold", gis_pkg::ST_PREP_A, o_state);
    sel = 1'b1;
    wait_st(gis_pkg::ST_INT_A, 4);
    $display("test gapped done");
  endtask

  task automatic t_seamless();
    int t4;
    repeat (2) @(negedge i_clk);
    sel = 1'b0;
    wait_st(gis_pkg::ST_INT_B_MEAS_A, 4);
    t4 = cyc;
    rt.delete();
    rs.delete();
    while (o_measure_busy === 1'b1 && cyc - t4 < 200) @(negedge i_clk);
    chk_in("busy", SC - 1, SC + 2, cyc - t4);
    repeat (10) @(negedge i_clk);
    chk("seamless", gis_pkg::ST_INT_B_MEAS_A, o_state);
    chk("side", 1'b0, rs[0]);
    sel = 1'b1;
    wait_st(gis_pkg::ST_INT_A_MEAS_B, 4);
    $display("test seamless done");
  endtask

  task automatic t_fall();
    slow = 1'b1;
    rt.delete();
    rs.delete();
    repeat (5) @(negedge i_clk);
    sel = 1'b0;
    wait_st(gis_pkg::ST_MEAS_B_A, 4);
    for (int k = 0; k < 100 && rt.size() == 0; k++) @(negedge i_clk);
    repeat (5) @(negedge i_clk);
    chk("ready held", 1'b0, o_data_ready_n);
    wait_st(gis_pkg::ST_INT_B, 200);
    tail3({gis_pkg::ST_MEAS_B_A, gis_pkg::ST_PREP_B, gis_pkg::ST_INT_B});
    chk("sides", 2'b10, {rs[0], rs[1]});
    chk("int b", 1'b1, int_b);
    chk("ready clear", 1'b1, o_data_ready_n);
    $display("test fall done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Run takes under a thousand cycles; the limit leaves wide margin
  initial begin
    #50000;
    failures++;
    $display("unexpected watchdog expected done seen hang");
    final_report();
  end

  initial begin
    t_reset();
    t_gapped();
    t_seamless();
    t_fall();
    final_report();
  end
endmodule // tb_gapped_integration_sequencer
`default_nettype wire
